/* File: logic/rbc_top.sv */
// reset sequencer, two-stage brownout monitor and code read protection gate
// Functional notes
// - four sources make chip reset
// - source drives reset pin low, starts timer
// - hold until pin, oscillator, count, flash
// - pin high on release; brownout waits supply
// - release with defaults, boot at address 0
// - first brownout threshold raises interrupt request
// - first stage readable in status flag
// - second threshold holds chip reset
// - thresholds use hysteresis, stable detection
// - pattern selects protection; application calls stay
// - level one: no debug, keep sector 0
// - level two: no debug, erase only
// - level three: nothing, override ignored
// - run internal oscillator, timer confirms main
`timescale 1ns/1ps
`default_nettype none
module rbc_top #(
   parameter int WAKE_CYCLES = rbc_pkg::RBC_WAKE_CYCLES
) (
   // clock and power-on reset
   input wire logic CLK,
   input wire logic RESET_N,
   // reset sources (pins and analog comparators, asynchronous)
   input wire logic EXT_RESET_N,
   input wire logic WATCHDOG_RESET,
   input wire logic SUPPLY_USABLE,
   input wire logic BOD_STAGE1_LOW,
   input wire logic BOD_STAGE2_LOW,
   // clock and flash status
   input wire logic MAIN_OSC_RUNNING,
   input wire logic FLASH_INIT_DONE,
   // protection word and override pin
   input wire logic [31:0] PROT_WORD,
   input wire logic BOOT_LOADER_OVERRIDE_PIN,
   // reset outputs
   output logic CHIP_RESET_N,
   output logic RESET_OUTPUT_PIN,
   output logic [31:0] BOOT_ADDR,
   output logic CLK_SEL_MAIN,
   // brownout outputs
   output logic BOD_IRQ,
   output logic BOD_STATUS,
   // protection outputs
   output var rbc_pkg::rbc_prot_t PROT_LEVEL,
   output logic JTAG_ENABLE,
   output var rbc_pkg::rbc_bl_t BOOT_LOADER_MODE,
   output logic BOOT_LOADER_ENTRY,
   output logic APP_FLASH_CALLS_ENABLE
);
   import rbc_pkg::*;
   // the wake counter is 16 bits wide and must end at a nonzero count
   if (WAKE_CYCLES < 1 || WAKE_CYCLES > 65535) begin : g_bad_wake
      $error("WAKE_CYCLES out of range");
   end

   typedef enum logic [1:0] {RBC_ST_RESET, RBC_ST_WAIT, RBC_ST_RUN} rbc_state_t;

   rbc_sync_if #(.W(6)) sif ();
   // bit order: ext released, watchdog, usable, bod1, bod2, osc
   assign sif.raw = {MAIN_OSC_RUNNING, BOD_STAGE2_LOW, BOD_STAGE1_LOW,
                     SUPPLY_USABLE, WATCHDOG_RESET, EXT_RESET_N};
   rbc_sync #(.W(6), .INIT(6'h00)) u_sync (
      .clk(CLK),
      .reset_n(RESET_N),
      .sif(sif)
   );

   logic ext_rel, wdog, usable, bod1, bod2, osc_run;
   assign ext_rel = sif.level[0];
   assign wdog = sif.level[1];
   assign usable = sif.level[2];
   assign bod1 = sif.level[3];
   assign bod2 = sif.level[4];
   assign osc_run = sif.level[5];

   // the override is a pin as well; a raw sample at release could be metastable
   rbc_sync_if #(.W(1)) ovr_if ();
   assign ovr_if.raw = BOOT_LOADER_OVERRIDE_PIN;
   rbc_sync #(.W(1), .INIT(6'h00)) u_sync_ovr (
      .clk(CLK),
      .reset_n(RESET_N),
      .sif(ovr_if)
   );
   logic ovr_pin;
   assign ovr_pin = ovr_if.level[0];

   // any source; power-on covered by supply not usable
   logic any_src;
   assign any_src = !ext_rel || wdog || bod2 || !usable;

   rbc_state_t st_q, st_d;
   logic [15:0] cnt_q, cnt_d;
   logic bod_rst_q, bod_rst_d;
   logic pin_q, pin_d;
   logic osc_ok_q, osc_ok_d;
   logic [31:0] prot_word_q, prot_word_d;
   logic override_q, override_d;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      bod_rst_d = bod_rst_q;
      pin_d = pin_q;
      osc_ok_d = osc_ok_q;
      prot_word_d = prot_word_q;
      override_d = override_q;
      unique case (st_q)
         RBC_ST_RESET: begin
            cnt_d = 16'h0000;
            pin_d = 1'b0;
            osc_ok_d = 1'b0;
            if (!any_src) begin
               st_d = RBC_ST_WAIT;
            end
         end
         RBC_ST_WAIT: begin
            if (any_src) begin
               st_d = RBC_ST_RESET;
            end else begin
               // fixed count only runs while the oscillator is running
               if (osc_run && cnt_q != WAKE_CYCLES[15:0]) begin
                  cnt_d = cnt_q + 16'h0001;
               end
               if (ext_rel && osc_run && cnt_q == WAKE_CYCLES[15:0] && FLASH_INIT_DONE) begin
                  st_d = RBC_ST_RUN;
                  osc_ok_d = 1'b1;
                  // protection word captured at the release edge, never under reset
                  prot_word_d = PROT_WORD;
                  override_d = ovr_pin;
               end
            end
         end
         RBC_ST_RUN: begin
            if (any_src) begin
               st_d = RBC_ST_RESET;
            end
         end
         default: st_d = RBC_ST_RESET;
      endcase
      // brownout reset remembered until supply recovers above threshold
      if (bod2) begin
         bod_rst_d = 1'b1;
      end else if (usable && !bod1 && !bod2) begin
         bod_rst_d = 1'b0;
      end
      if (st_d == RBC_ST_RUN && !bod_rst_d && !bod1) begin
         pin_d = 1'b1;
      end else if (st_d == RBC_ST_RUN && !bod_rst_d) begin
         pin_d = 1'b1;
      end else if (st_d != RBC_ST_RUN) begin
         pin_d = 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st_q <= RBC_ST_RESET;
         cnt_q <= 16'h0000;
         bod_rst_q <= 1'b0;
         pin_q <= 1'b0;
         osc_ok_q <= 1'b0;
         prot_word_q <= 32'h0000_0000;
         override_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         bod_rst_q <= bod_rst_d;
         pin_q <= pin_d;
         osc_ok_q <= osc_ok_d;
         prot_word_q <= prot_word_d;
         override_q <= override_d;
      end
   end

   // brownout first stage; hysteresis lives in the analog comparator, filter adds stability
   logic irq_q, irq_d;
   always_comb begin
      irq_d = bod1;
   end
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // protection decode of the word about to be held, so the level flop
   // changes on the release edge itself and debug never opens for a cycle
   rbc_prot_t lvl_d, lvl_q, lvl;
   always_comb begin
      if (prot_word_d == RBC_PAT_LVL3) begin
         lvl_d = RBC_PROT_THREE;
      end else if (prot_word_d == RBC_PAT_LVL2) begin
         lvl_d = RBC_PROT_TWO;
      end else if (prot_word_d == RBC_PAT_LVL1) begin
         lvl_d = RBC_PROT_ONE;
      end else begin
         lvl_d = RBC_PROT_NONE;
      end
   end
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         lvl_q <= RBC_PROT_NONE;
      end else begin
         lvl_q <= lvl_d;
      end
   end
   assign lvl = lvl_q;

   logic running;
   assign running = (st_q == RBC_ST_RUN);
   assign CHIP_RESET_N = running;
   assign RESET_OUTPUT_PIN = pin_q;
   assign BOOT_ADDR = RBC_BOOT_ADDR;
   assign CLK_SEL_MAIN = osc_ok_q;
   assign BOD_IRQ = irq_q;
   assign BOD_STATUS = irq_q;
   assign PROT_LEVEL = lvl;
   assign APP_FLASH_CALLS_ENABLE = running;
   assign JTAG_ENABLE = running && (lvl == RBC_PROT_NONE);
   always_comb begin
      unique case (lvl)
         RBC_PROT_NONE: BOOT_LOADER_MODE = RBC_BL_FULL;
         RBC_PROT_ONE: BOOT_LOADER_MODE = RBC_BL_KEEP_SECTOR0;
         RBC_PROT_TWO: BOOT_LOADER_MODE = RBC_BL_ERASE_ONLY;
         RBC_PROT_THREE: BOOT_LOADER_MODE = RBC_BL_NONE;
      endcase
   end
   // override pin is sampled at release; ignored at the top level
   assign BOOT_LOADER_ENTRY = running && override_q && (lvl != RBC_PROT_THREE);

   // assertions
   sequence s_reset_held;
      !CHIP_RESET_N && !RESET_OUTPUT_PIN;
   endsequence

   sequence s_bod_latched;
      bod_rst_q ##0 !CHIP_RESET_N;
   endsequence

   property p_src_holds;
      @(posedge CLK) disable iff (!RESET_N)
      any_src |=> s_reset_held;
   endproperty
   a_src_holds: assert property (p_src_holds) else $error("source did not hold reset");

   property p_release_cond;
      @(posedge CLK) disable iff (!RESET_N)
      $rose(CHIP_RESET_N) |-> $past(ext_rel) && $past(osc_run) && $past(FLASH_INIT_DONE)
         && $past(cnt_q) == WAKE_CYCLES[15:0];
   endproperty
   a_release_cond: assert property (p_release_cond) else $error("release without conditions");

   property p_pin_follows;
      @(posedge CLK) disable iff (!RESET_N)
      RESET_OUTPUT_PIN |-> CHIP_RESET_N && !bod_rst_q;
   endproperty
   a_pin_follows: assert property (p_pin_follows) else $error("reset pin high too early");

   property p_bod_irq;
      @(posedge CLK) disable iff (!RESET_N)
      bod1 |=> BOD_IRQ && BOD_STATUS;
   endproperty
   a_bod_irq: assert property (p_bod_irq) else $error("brownout flag missing");

   property p_bod_reset;
      @(posedge CLK) disable iff (!RESET_N)
      bod2 |=> s_bod_latched;
   endproperty
   a_bod_reset: assert property (p_bod_reset) else $error("brownout reset missing");

   property p_lvl_jtag;
      @(posedge CLK) disable iff (!RESET_N)
      (lvl != RBC_PROT_NONE) |-> !JTAG_ENABLE;
   endproperty
   a_lvl_jtag: assert property (p_lvl_jtag) else $error("debug open while protected");

   property p_lvl3_bl;
      @(posedge CLK) disable iff (!RESET_N)
      (lvl == RBC_PROT_THREE) |-> !BOOT_LOADER_ENTRY && BOOT_LOADER_MODE == RBC_BL_NONE;
   endproperty
   a_lvl3_bl: assert property (p_lvl3_bl) else $error("boot loader open at level three");

   property p_app_calls;
      @(posedge CLK) disable iff (!RESET_N)
      CHIP_RESET_N |-> APP_FLASH_CALLS_ENABLE;
   endproperty
   a_app_calls: assert property (p_app_calls) else $error("application calls blocked");

   property p_clk_sel;
      @(posedge CLK) disable iff (!RESET_N)
      $fell(CHIP_RESET_N) |=> !CLK_SEL_MAIN;
   endproperty
   a_clk_sel: assert property (p_clk_sel) else $error("main clock kept after reset");

   property p_bod_irq_clear;
      @(posedge CLK) disable iff (!RESET_N)
      !bod1 |=> !BOD_IRQ && !BOD_STATUS;
   endproperty
   a_bod_irq_clear: assert property (p_bod_irq_clear) else $error("brownout flag stuck");
endmodule : rbc_top
`default_nettype wire

/* File: pkg/rbc_pkg.sv */
// shared constants and types for the reset, brownout and code protection block
`default_nettype none
package rbc_pkg;
   // fixed wake-up count after oscillator is seen running
   localparam int RBC_WAKE_CYCLES = 4096;
   localparam logic [31:0] RBC_BOOT_ADDR = 32'h0000_0000;
   // protection patterns held in the dedicated flash word
   localparam logic [31:0] RBC_PAT_LVL1 = 32'h1234_5678;
   localparam logic [31:0] RBC_PAT_LVL2 = 32'h8765_4321;
   localparam logic [31:0] RBC_PAT_LVL3 = 32'h4321_8765;
   localparam int RBC_SYNC_STAGES = 3;
   typedef enum logic [1:0] {
      RBC_PROT_NONE,
      RBC_PROT_ONE,
      RBC_PROT_TWO,
      RBC_PROT_THREE
   } rbc_prot_t;
   typedef enum logic [1:0] {
      RBC_BL_FULL,
      RBC_BL_KEEP_SECTOR0,
      RBC_BL_ERASE_ONLY,
      RBC_BL_NONE
   } rbc_bl_t;
endpackage : rbc_pkg
`default_nettype wire

/* File: pkg/rbc_sync_if.sv */
// interface carrying raw and filtered levels between top and synchroniser
`timescale 1ns/1ps
`default_nettype none
interface rbc_sync_if #(parameter int W = 6);
   logic [W-1:0] raw;
   logic [W-1:0] level;
   logic [W-1:0] changed;
   modport top (output raw, input level, input changed);
   modport sync (input raw, output level, output changed);
endinterface : rbc_sync_if
`default_nettype wire

/* File: logic/rbc_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module rbc_sync #(
   parameter int W = 6,
   parameter logic [5:0] INIT = 6'h00
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // levels
   rbc_sync_if.sync sif
);
   import rbc_pkg::*;
   logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
   logic [W-1:0] lvl_d;
   // the reset pattern is only six bits wide, so wider groups cannot be served
   if (W < 1 || W > 6) begin : g_bad_width
      $error("rbc_sync width outside 1 to 6");
   end
   always_comb begin
      lvl_d = lvl_q;
      // a change counts once the second and third stages agree
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            lvl_d[i] = s3_q[i];
         end
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_q <= INIT[W-1:0];
         s2_q <= INIT[W-1:0];
         s3_q <= INIT[W-1:0];
         lvl_q <= INIT[W-1:0];
      end else begin
         s1_q <= sif.raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end
   assign sif.level = lvl_q;
   assign sif.changed = lvl_q ^ lvl_d;
endmodule : rbc_sync
`default_nettype wire

/* File: test/rbc_partner.sv */
// far-side model: main oscillator and flash controller that feed the block, driven from the bench
`timescale 1ns/1ps
`default_nettype none
module rbc_partner #(
   parameter int FLASH_DLY = 5
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // control from the bench
   input wire logic osc_en,
   // modelled outputs
   output var logic osc_running,
   output var logic flash_done
);
   int cnt_q;
   // flash init restarts whenever the oscillator drops, like the real part
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 0;
         osc_running <= 1'b0;
         flash_done <= 1'b0;
      end else begin
         osc_running <= osc_en;
         cnt_q <= osc_running ? ((cnt_q < FLASH_DLY) ? cnt_q + 1 : cnt_q) : 0;
         flash_done <= osc_running && (cnt_q >= FLASH_DLY);
      end
   end
endmodule : rbc_partner
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the reset, brownout and protection block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rbc_pkg::*;
   localparam int WAKE = 8;
   logic clk = 1'b0, reset_n = 1'b0, ext_n = 1'b1, wd = 1'b0, sup = 1'b1;
   logic bod1 = 1'b0, bod2 = 1'b0, osc_en = 1'b1, ovr = 1'b1;
   logic [31:0] word = 32'h0000_0000;
   logic osc, fdone, chip_n, pin, sel, irq, stat, jtag, entry, app;
   logic [31:0] baddr;
   rbc_prot_t lvl;
   rbc_bl_t mode;
   int fails = 0, num_checks = 0;
   always #5 clk = ~clk;
   rbc_partner u_rbc_partner (.clk(clk), .reset_n(reset_n), .osc_en(osc_en),
      .osc_running(osc), .flash_done(fdone));
   rbc_top #(.WAKE_CYCLES(WAKE)) u_rbc_top (.CLK(clk), .RESET_N(reset_n),
      .EXT_RESET_N(ext_n), .WATCHDOG_RESET(wd), .SUPPLY_USABLE(sup),
      .BOD_STAGE1_LOW(bod1), .BOD_STAGE2_LOW(bod2), .MAIN_OSC_RUNNING(osc),
      .FLASH_INIT_DONE(fdone), .PROT_WORD(word), .BOOT_LOADER_OVERRIDE_PIN(ovr),
      .CHIP_RESET_N(chip_n), .RESET_OUTPUT_PIN(pin), .BOOT_ADDR(baddr),
      .CLK_SEL_MAIN(sel), .BOD_IRQ(irq), .BOD_STATUS(stat), .PROT_LEVEL(lvl),
      .JTAG_ENABLE(jtag), .BOOT_LOADER_MODE(mode), .BOOT_LOADER_ENTRY(entry),
      .APP_FLASH_CALLS_ENABLE(app));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // bounded wait for chip reset release
   task automatic wait_rel;
      int n;
      n = 0;
      while (chip_n !== 1'b1 && n < 100) begin
         tick(1);
         n++;
      end
      check(chip_n, 1'b1);
   endtask : wait_rel
   task automatic set_src(input int i, input logic on);
      @(posedge clk);
      case (i)
         0: ext_n <= ~on;
         1: wd <= on;
         2: bod2 <= on;
         default: sup <= ~on;
      endcase
   endtask : set_src
   task automatic t_power_up;
      tick(WAKE);
      check(chip_n, 1'b0);
      wait_rel();
      check(pin, 1'b1);
      check(baddr, RBC_BOOT_ADDR);
      check(sel, 1'b1);
      check(app, 1'b1);
   endtask : t_power_up
   task automatic t_sources;
      for (int i = 0; i < 4; i++) begin
         set_src(i, 1'b1);
         tick(8);
         check(chip_n, 1'b0);
         check(pin, 1'b0);
         check(app, 1'b0);
         set_src(i, 1'b0);
         wait_rel();
         check(pin, 1'b1);
      end
   endtask : t_sources
   task automatic t_osc_hold;
      @(posedge clk);
      osc_en <= 1'b0;
      set_src(1, 1'b1);
      // a one-cycle pulse would be swallowed by the pin filter
      tick(8);
      set_src(1, 1'b0);
      tick(60);
      check(chip_n, 1'b0);
      check(sel, 1'b0);
      @(posedge clk);
      osc_en <= 1'b1;
      wait_rel();
      check(sel, 1'b1);
   endtask : t_osc_hold
   task automatic t_brownout;
      @(posedge clk);
      bod1 <= 1'b1;
      tick(8);
      check({irq, stat, chip_n}, 3'b111);
      tick(20);
      check(stat, 1'b1);
      set_src(2, 1'b1);
      tick(8);
      check(chip_n, 1'b0);
      set_src(2, 1'b0);
      tick(40);
      check(pin, 1'b0);
      @(posedge clk);
      bod1 <= 1'b0;
      tick(8);
      check(irq, 1'b0);
      wait_rel();
      check(pin, 1'b1);
   endtask : t_brownout
   task automatic t_protection;
      logic [31:0] pat [4];
      pat = '{32'h0000_0000, RBC_PAT_LVL1, RBC_PAT_LVL2, RBC_PAT_LVL3};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         word <= pat[i];
         // override low at level two, high but to be ignored at level three
         ovr <= (i != 2);
         set_src(1, 1'b1);
         tick(8);
         set_src(1, 1'b0);
         wait_rel();
         check(lvl, i);
         check(jtag, i == 0);
         check(mode, i);
         check(entry, i < 2);
         check(app, 1'b1);
      end
   endtask : t_protection
   task automatic summarize;
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : summarize
   // hang guard: the full sequence takes well under 2000 cycles
   initial begin
      #100000;
      fails++;
      summarize();
   end
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      t_power_up();
      t_sources();
      t_osc_hold();
      t_brownout();
      t_protection();
      summarize();
   end
endmodule : testbench
`default_nettype wire
